//--- rtl/ext_bus_defines.svh
// Constants of the external bus strobe controller: space codes, widths, reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH
`define SPACE_PROG       2'h0
`define SPACE_DATA       2'h1
`define SPACE_IO         2'h2
`define WAIT_W           3
`define ADDR_W           16
`define DATA_W           16
`define PINS_IDLE        7'h7B
`define PORTC0_DIR_RESET 1'h0
`endif

//--- rtl/ext_bus_pkg.sv
// Types shared by the external bus strobe controller and its bench.
// Assumes ext_bus_defines.svh is on the include path.
`include "ext_bus_defines.svh"
package ext_bus_pkg;
    typedef logic [1:0] space_t;
    typedef struct packed {
        space_t              space;
        logic                write;
        logic [`WAIT_W-1:0]  waits;
        logic [`ADDR_W-1:0]  addr;
        logic [`DATA_W-1:0]  wdata;
    } bus_req_s;
    typedef struct packed {
        logic [`DATA_W-1:0]  rdata;
        logic                was_write;
    } bus_rsp_s;
    // Pin bundle, all active-low except the direction pair.
    typedef struct packed {
        logic prog_n;
        logic data_n;
        logic io_n;
        logic rnw;
        logic wnr;
        logic rd_n;
        logic we_n;
    } bus_pins_s;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_WAIT  = 4'b0100,
        ST_DONE  = 4'b1000
    } bus_state_e;
endpackage

//--- rtl/external_bus_strobe_control.sv
// External memory interface strobe logic: space selects, direction, strobes, float.
// Assumes requests come from the CPU on clk; ready and emulation pins are asynchronous.
// Function
// RQ1: Data select low only during data access.
// RQ2: I/O select low only during I/O access.
// RQ3: Program select low only during program access.
// RQ4: Direction rests high, low during writes.
// RQ5: Inverted direction, high only during writes.
// RQ6: Read strobe low on every external read.
// RQ7: Write strobe low on every external write.
// RQ8: Data bus driven from write strobe fall.
// RQ9: Access strobe low on every external cycle.
// RQ10: All controls float under emulation condition; only pins_out floats, external_access_strobe_n stays driven.
// RQ11: Port C bit is input after reset.
// RQ12: Not ready stretches access, resampled each cycle.
// RQ13: Ready sampled only with wait states programmed.
// RQ14: At most one space select low.
`timescale 1ns/1ps
`include "ext_bus_defines.svh"
module external_bus_strobe_control (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    // Request stream from the CPU
    input  wire ext_bus_pkg::bus_req_s  req,
    input  wire logic                   req_valid,
    output logic                        req_ready,
    // Response stream to the CPU
    output ext_bus_pkg::bus_rsp_s       rsp,
    output logic                        rsp_valid,
    input  wire logic                   rsp_ready,
    // Strobe pins, with one output enable for pins_out only
    output ext_bus_pkg::bus_pins_s      pins_out,
    output logic                        pins_oe,
    output logic                        external_access_strobe_n,
    // Address and data pins
    output logic [`ADDR_W-1:0]          addr_out,
    output logic [`DATA_W-1:0]          data_out,
    output logic                        data_oe,
    input  wire logic [`DATA_W-1:0]     data_in,
    // Asynchronous pins
    input  wire logic                   ready_pin,
    input  wire logic                   emulation_pin0,
    input  wire logic                   emulation_pin1_float,
    input  wire logic                   test_reset,
    // Port C bit 0 direction
    input  wire logic                   port_c_bit0_dir_wr,
    input  wire logic                   port_c_bit0_dir_val,
    output logic                        port_c_bit0_dir
);
    import ext_bus_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    // No reset here: the chain has to keep following the pins through a reset.
    always_ff @(posedge clk) begin
        sync1_q <= {ready_pin, emulation_pin0, emulation_pin1_float, test_reset};
        sync2_q <= sync1_q;
    end
    logic ready_s;
    logic float_s;
    assign ready_s = sync2_q[3];
    assign float_s = sync2_q[2] && !sync2_q[1] && !sync2_q[0];

    // ----------------------------------------------------------------
    // Two-entry response buffer
    // ----------------------------------------------------------------
    bus_rsp_s   buf_q [2];
    logic [1:0] cnt_q;
    logic       rd_ptr_q;
    logic       wr_ptr_q;
    logic       push;
    logic       pop;
    bus_rsp_s   push_data;
    logic [1:0] cnt_d;
    assign pop   = rsp_valid && rsp_ready;
    assign cnt_d = cnt_q + {1'h0, push} - {1'h0, pop};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q    <= 2'h0;
            rd_ptr_q <= 1'h0;
            wr_ptr_q <= 1'h0;
        end else begin
            if (push) begin
                buf_q[wr_ptr_q] <= push_data;
                wr_ptr_q        <= !wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= !rd_ptr_q;
            end
            cnt_q <= cnt_d;
        end
    end

    // Output register of the buffer keeps rsp straight from a flip-flop.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp_valid <= 1'h0;
            rsp       <= '0;
        end else begin
            rsp_valid <= (cnt_q - {1'h0, pop}) != 2'h0;
            rsp       <= buf_q[rd_ptr_q ^ pop];
        end
    end

    // ----------------------------------------------------------------
    // Bus cycle sequencer
    // ----------------------------------------------------------------
    function automatic bus_pins_s active_pins(input space_t sp, input logic wr);
        bus_pins_s p;
        p        = `PINS_IDLE;
        p.prog_n = (sp != `SPACE_PROG); // RQ3 RQ14
        p.data_n = (sp != `SPACE_DATA); // RQ1 RQ14
        p.io_n   = (sp != `SPACE_IO);   // RQ2 RQ14
        p.rnw    = !wr;                 // RQ4
        p.wnr    = wr;                  // RQ5
        p.rd_n   = wr;                  // RQ6
        p.we_n   = !wr;                 // RQ7
        return p;
    endfunction

    bus_state_e         state_q;
    bus_req_s           cur_q;
    logic [`WAIT_W-1:0] wcnt_q;
    logic               take;

    assign take      = req_valid && req_ready;
    assign push      = (state_q == ST_DONE);
    assign push_data = '{rdata: data_in, was_write: cur_q.write};

    // Accept a request only while a buffer slot is guaranteed free, so a stalled
    // receiver back-pressures the CPU instead of dropping a read word.
    // The flag is registered from the next buffer count; a float condition that
    // appears while it stands high is honoured one cycle late.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_ready <= 1'h0;
        end else begin
            req_ready <= (state_q == ST_IDLE) && !take && (cnt_d == 2'h0) && !float_s;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cur_q   <= '0;
            wcnt_q  <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        cur_q   <= req;
                        wcnt_q  <= req.waits;
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    state_q <= (cur_q.waits == '0) ? ST_DONE : ST_WAIT; // RQ13
                end
                ST_WAIT: begin
                    // The last wait count is also the first cycle that looks at ready.
                    if (wcnt_q > `WAIT_W'(1)) begin
                        wcnt_q <= wcnt_q - 1'h1;
                    end else if (ready_s) begin // RQ12
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin registers
    // ----------------------------------------------------------------
    logic in_cycle;
    assign in_cycle = take || (state_q == ST_SETUP) || (state_q == ST_WAIT);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pins_out                 <= `PINS_IDLE;
            external_access_strobe_n <= 1'h1;
            pins_oe                  <= 1'h1;
            data_oe                  <= 1'h0;
            addr_out                 <= '0;
            data_out                 <= '0;
        end else begin
            pins_oe <= !float_s; // RQ10
            if (take) begin
                pins_out                 <= active_pins(req.space, req.write);
                external_access_strobe_n <= 1'h0; // RQ9
                addr_out                 <= req.addr;
                data_out                 <= req.wdata;
                data_oe                  <= req.write; // RQ8
            end else if (!in_cycle) begin
                pins_out                 <= `PINS_IDLE;
                external_access_strobe_n <= 1'h1;
                data_oe                  <= 1'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Port C bit 0 direction
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_c_bit0_dir <= `PORTC0_DIR_RESET; // RQ11
        end else if (port_c_bit0_dir_wr) begin
            port_c_bit0_dir <= port_c_bit0_dir_val;
        end
    end
endmodule

//--- bench/ext_bus_strobe_properties.sv
// Checker of the strobe controller's pin behaviour, bound to its top module.
// Assumes ext_bus_pkg is compiled first; sees only the top module's ports.
`timescale 1ns/1ps
module ext_bus_strobe_checker (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   rst_n,
    // Observed ports
    input wire logic                   req_valid,
    input wire logic                   req_ready,
    input wire ext_bus_pkg::bus_pins_s pins_out,
    input wire logic                   pins_oe,
    input wire logic                   external_access_strobe_n,
    input wire logic                   data_oe,
    input wire logic                   emulation_pin0,
    input wire logic                   emulation_pin1_float,
    input wire logic                   test_reset,
    input wire logic                   port_c_bit0_dir
);
    import ext_bus_pkg::*;
    // The float pin pattern is asynchronous, so it must hold for four edges.
    wire float_cond = !emulation_pin1_float && !test_reset && emulation_pin0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_one; $countones(~pins_out[6:4]) <= 1; endproperty
    a_one: assert property (p_one) else $error("two space selects low");
    property p_inv; pins_out.wnr != pins_out.rnw; endproperty
    a_inv: assert property (p_inv) else $error("direction pair equal");
    property p_rd; !pins_out.rd_n |-> pins_out.rnw && pins_out.we_n; endproperty
    a_rd: assert property (p_rd) else $error("read with write direction");
    property p_we; !pins_out.we_n |-> !pins_out.rnw && data_oe; endproperty
    a_we: assert property (p_we) else $error("write without direction or data");
    property p_sel; (pins_out[6:4] != 3'h7) == !external_access_strobe_n; endproperty
    a_sel: assert property (p_sel) else $error("select and access strobe differ");
    property p_take; req_valid && req_ready |=> !external_access_strobe_n; endproperty
    a_take: assert property (p_take) else $error("access strobe late");
    property p_float; float_cond [*4] |-> !pins_oe; endproperty
    a_float: assert property (p_float) else $error("pins driven while floating");
    property p_drive; (!float_cond) [*4] |-> pins_oe; endproperty
    a_drive: assert property (p_drive) else $error("pins floating wrongly");
    property p_dir; disable iff (1'b0) !rst_n |=> !port_c_bit0_dir; endproperty
    a_dir: assert property (p_dir) else $error("port bit not input after reset");
endmodule
bind external_bus_strobe_control ext_bus_strobe_checker i_chk (.clk, .rst_n, .req_valid,
    .req_ready, .pins_out, .pins_oe, .external_access_strobe_n, .data_oe, .emulation_pin0,
    .emulation_pin1_float, .test_reset, .port_c_bit0_dir);

//--- bench/ext_mem_model.sv
// External memory: read data from address and space, slow ready, write capture.
// Assumes the strobe controller's pins; released data lines toggle each cycle.
`timescale 1ns/1ps
`include "ext_bus_defines.svh"
module ext_mem_model (
    // Clock and pins
    input wire logic                   clk,
    input wire ext_bus_pkg::bus_pins_s pins_out,
    input wire logic                   pins_oe,
    input wire logic [`ADDR_W-1:0]     addr_out,
    input wire logic [`DATA_W-1:0]     data_out,
    input wire logic                   data_oe,
    input wire logic                   slow,
    output logic [`DATA_W-1:0]         data_in,
    output logic                       ready_pin,
    // Last write seen
    output logic [`DATA_W-1:0]         wdata_seen,
    output logic [1:0]                 sel_seen
);
    logic [`DATA_W-1:0] last_q;
    logic [1:0]         wait_q;
    logic [1:0]         sel;
    assign sel = !pins_out.prog_n ? 2'h0 : !pins_out.data_n ? 2'h1 : 2'h2;
    always_ff @(posedge clk) begin
        last_q <= data_in;
        wait_q <= (pins_out.rd_n && pins_out.we_n) ? 2'h3 : wait_q - 2'(wait_q != 0);
        if (!pins_out.we_n && data_oe) begin
            wdata_seen <= data_out;
            sel_seen <= sel;
        end
    end
    assign ready_pin = !slow || wait_q == 2'h0;
    assign data_in = (!pins_out.rd_n && pins_oe) ? ~addr_out ^ {14'h0, sel} : ~last_q;
endmodule

//--- bench/tb_top.sv
// Bench: random accesses checked against a queue model, float and port bit checks.
// Assumes the controller, its package, checker and memory model are compiled.
`timescale 1ns/1ps
`include "ext_bus_defines.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
    import ext_bus_pkg::*;
    logic clk = 0, rst_n = 0, req_valid = 0, req_ready, rsp_valid, rsp_ready = 0;
    logic pins_oe, data_oe, strobe_n, ready_pin, slow = 0, port_c_bit0_dir;
    logic emulation_pin0 = 0, emulation_pin1_float = 1, test_reset = 0;
    logic port_c_bit0_dir_wr = 0, port_c_bit0_dir_val = 0;
    logic [15:0] addr_out, data_out, data_in, wdata_seen;
    logic [1:0] sel_seen;
    bus_req_s req = '0, a, e;
    bus_req_s q[$];
    bus_rsp_s rsp;
    bus_pins_s pins_out;
    logic [31:0] r = 32'hB376;
    int fail_count = 0, n_tests = 0, n;
    always #10 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    external_bus_strobe_control i_dut (.clk, .rst_n, .req, .req_valid, .req_ready, .rsp,
        .rsp_valid, .rsp_ready, .pins_out, .pins_oe, .external_access_strobe_n(strobe_n),
        .addr_out, .data_out, .data_oe, .data_in, .ready_pin, .emulation_pin0,
        .emulation_pin1_float, .test_reset, .port_c_bit0_dir_wr, .port_c_bit0_dir_val,
        .port_c_bit0_dir);
    ext_mem_model i_mem (.clk, .pins_out, .pins_oe, .addr_out, .data_out, .data_oe, .slow,
        .data_in, .ready_pin, .wdata_seen, .sel_seen);
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wait_hi(input bit on_rsp);
        n = 0;
        while ((on_rsp ? rsp_valid : req_ready) !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 200) begin
                fail_count++;
                complete_run();
            end
        end
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        `CHK(port_c_bit0_dir, 1'b0)
        `CHK(pins_out, `PINS_IDLE)
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    // Request held until taken, then the response is left stalled for a while.
    task automatic access(input int stall);
        req = a;
        req_valid = 1'b1;
        wait_hi(1'b0);
        q.push_back(a);
        @(negedge clk);
        req_valid = 1'b0;
        wait_hi(1'b1);
        e = q.pop_front();
        if (e.waits == 0) `CHK(n, 3)
        if (e.waits != 0 && !slow) `CHK(n, 3 + int'(e.waits))
        if (e.waits != 0 && slow) `CHK(n >= 6, 1'b1)
        repeat (stall) @(negedge clk);
        `CHK(rsp.was_write, e.write)
        if (!e.write) `CHK(rsp.rdata, ~e.addr ^ {14'h0, e.space})
        if (e.write) `CHK({sel_seen, wdata_seen}, {e.space, e.wdata})
        rsp_ready = 1'b1;
        @(negedge clk);
        rsp_ready = 1'b0;
    endtask
    initial begin
        @(negedge clk);
        do_reset();
        for (int i = 0; i < 36; i++) begin
            r = lfsr(r);
            a = {space_t'(i % 3), 1'(i / 3 % 2), r[2:0], r[31:16], r[15:0]};
            slow = r[3];
            access(int'(r[5:4]));
        end
        for (int c = 0; c < 8; c++) begin
            {emulation_pin1_float, test_reset, emulation_pin0} = 3'(c);
            repeat (6) @(negedge clk);
            `CHK(pins_oe, c != 1)
            if (c == 1) `CHK(req_ready, 1'b0)
        end
        {emulation_pin1_float, test_reset, emulation_pin0} = 3'h4;
        {port_c_bit0_dir_wr, port_c_bit0_dir_val} = 2'h3;
        @(negedge clk);
        port_c_bit0_dir_wr = 1'b0;
        @(negedge clk);
        `CHK(port_c_bit0_dir, 1'b1)
        do_reset();
        access(0);
        complete_run();
    end
endmodule
